/* File: rtl/fps_output_control.v */
// Output control of a fail-safe proximity sensor: zones, lockout, setting aid, clock pass-through
//
// Functional notes
// - Output enabled only while target is damped inside the enable zone.
// - Entering the enable zone switches output on regardless of LED timing.
// - After long undamping or power-on in zone, LED lights after 3 s.
// - After short undamping, LED lights at once in the enable zone.
// - Undamping turns output and LED off without added delay.
// - Close zone: output off at once, LED dark after 2 s.
// - Over 2 s in close zone locks out later enabling.
// - Lockout cleared by undamping beyond 10 mm over 2 s, or reset.
// - Over 5 s in close zone starts setting aid, LED flashing.
// - During setting aid the output stays at logic 0.
// - Setting aid: LED off in enable zone, flashing outside it.
// - Setting aid ends after undamping over 2 s, or power removal.
// - Enabled and fault free, output repeats test clock after fixed offset.
// - Low test pulses up to 1.0 ms are not input changes.
// - Missing offset or stuck-high output appears only under faults.
// - A cross fault holds the output permanently at logic 1.
// - Leaving enable zone: output off within 20 ms, low meanwhile.
// - Enable decision takes typically 100 ms, never over 200 ms.
// - Test clock switched off: output follows within 2 ms.
// - Enable to first passed rising edge: typically 40 ms, at most 100 ms.
// - Safety faults answered within one test clock period.
`timescale 1ns/1ps
`include "fps_output_control_defs.vh"

module fps_output_control #(
    parameter [31:0] CLOSE_DWELL_CYC = `FPS_CLOSE_DWELL_CYC,
    parameter [31:0] UNDAMP_RELEASE_CYC = `FPS_UNDAMP_RELEASE_CYC,
    parameter [31:0] LED_DELAY_CYC = `FPS_LED_DELAY_CYC,
    parameter [31:0] AID_DELAY_CYC = `FPS_AID_DELAY_CYC,
    parameter [31:0] ENABLE_TIME_CYC = `FPS_ENABLE_TIME_CYC,
    parameter [31:0] TEST_PULSE_CYC = `FPS_TEST_PULSE_CYC,
    parameter [31:0] OFFSET_CYC = `FPS_OFFSET_CYC,
    parameter [31:0] CLOCK_LOSS_CYC = `FPS_CLOCK_LOSS_CYC,
    parameter [31:0] FLASH_HALF_CYC = `FPS_FLASH_HALF_CYC,
    parameter [31:0] FAULT_HALF_CYC = `FPS_FAULT_HALF_CYC
)(
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Zone flags from the sensing front end, same clock
    input wire zone_close,
    input wire zone_enable,
    input wire zone_undamped,
    // Pins from outside the clock domain
    input wire test_clock_input,
    input wire cross_fault_pin,
    // Safety output and yellow indicator
    output reg safety_out,
    output reg led_yellow
);

    // =================================================================
    // Helpers

    // Saturating counter reached its limit
    function reached;
        input [31:0] cnt;
        input [31:0] lim;
        begin
            reached = (cnt >= lim);
        end
    endfunction

    // Saturating increment
    function [31:0] bump;
        input [31:0] cnt;
        begin
            bump = (cnt == 32'hFFFFFFFF) ? cnt : cnt + 32'h00000001;
        end
    endfunction

    // =================================================================
    // Pin synchronisers

    wire [1:0] pin_raw;
    reg [1:0] pin_meta;
    reg [1:0] pin_sync;
    genvar gi;

    assign pin_raw = {cross_fault_pin, test_clock_input};

    // Two flip-flops per pin; the first stage feeds only the second
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    wire clk_in_sync;
    wire cross_sync;

    assign clk_in_sync = pin_sync[0];
    assign cross_sync = pin_sync[1];

    // =================================================================
    // Zone classification and dwell timer

    reg [1:0] zone;
    reg [1:0] next_zone;
    reg [31:0] dwell;

    // Close wins over enable so a target pressed on the face is never enabled
    always @* begin
        if (zone_close) begin
            next_zone = `FPS_ZONE_CLOSE;
        end else if (zone_enable) begin
            next_zone = `FPS_ZONE_ENABLE;
        end else if (zone_undamped) begin
            next_zone = `FPS_ZONE_UNDAMPED;
        end else begin
            next_zone = `FPS_ZONE_OUTSIDE;
        end
    end

    // Dwell restarts on every zone change
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            zone <= `FPS_ZONE_OUTSIDE;
            dwell <= 32'h00000000;
        end else begin
            zone <= next_zone;
            if (next_zone != zone) begin
                dwell <= 32'h00000000;
            end else begin
                dwell <= bump(dwell);
            end
        end
    end

    wire in_close;
    wire in_enable;
    wire in_undamped;
    wire entering_enable;
    wire undamp_release;

    assign in_close = (zone == `FPS_ZONE_CLOSE);
    assign in_enable = (zone == `FPS_ZONE_ENABLE);
    assign in_undamped = (zone == `FPS_ZONE_UNDAMPED);
    assign entering_enable = in_enable && (dwell == 32'h00000000);
    assign undamp_release = in_undamped && reached(dwell, UNDAMP_RELEASE_CYC);

    // =================================================================
    // Lockout, setting aid and LED delay arming

    reg lockout;
    reg setting_aid;
    reg led_delay_armed;
    reg led_delay_mode;

    // Reset doubles as the supply interruption that releases everything
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lockout <= 1'b0;
            setting_aid <= 1'b0;
            led_delay_armed <= 1'b1;
            led_delay_mode <= 1'b0;
        end else begin
            if (in_close && reached(dwell, CLOSE_DWELL_CYC)) begin
                lockout <= 1'b1;
            end else if (undamp_release) begin
                lockout <= 1'b0;
            end
            if (in_close && reached(dwell, AID_DELAY_CYC)) begin
                setting_aid <= 1'b1;
            end else if (undamp_release) begin
                setting_aid <= 1'b0;
            end
            // Long undamping arms the delayed LED, entry consumes the choice
            if (undamp_release) begin
                led_delay_armed <= 1'b1;
            end else if (entering_enable) begin
                led_delay_armed <= 1'b0;
            end
            if (entering_enable) begin
                led_delay_mode <= led_delay_armed;
            end
        end
    end

    // =================================================================
    // Cross fault latch

    reg cross_fault;

    // Sticky until power is removed
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cross_fault <= 1'b0;
        end else if (cross_sync) begin
            cross_fault <= 1'b1;
        end
    end

    // =================================================================
    // Test clock conditioning

    reg clk_filt;
    reg [31:0] low_cnt;

    // High passes at once; low must outlast a test pulse to count
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_filt <= 1'b0;
            low_cnt <= 32'h00000000;
        end else if (clk_in_sync) begin
            clk_filt <= 1'b1;
            low_cnt <= 32'h00000000;
        end else begin
            low_cnt <= bump(low_cnt);
            if (reached(low_cnt, TEST_PULSE_CYC)) begin
                clk_filt <= 1'b0;
            end
        end
    end

    reg clk_pass;
    reg [31:0] offset_cnt;

    // Each level change reaches the output only after the fixed offset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_pass <= 1'b0;
            offset_cnt <= 32'h00000000;
        end else if (clk_filt == clk_pass) begin
            offset_cnt <= 32'h00000000;
        end else if (reached(offset_cnt, OFFSET_CYC)) begin
            clk_pass <= clk_filt;
            offset_cnt <= 32'h00000000;
        end else begin
            offset_cnt <= bump(offset_cnt);
        end
    end

    reg clk_prev;
    reg [31:0] since_rise;
    reg clock_alive;

    // A clock stuck high must not become a stuck-high output
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_prev <= 1'b0;
            since_rise <= 32'h00000000;
            clock_alive <= 1'b0;
        end else begin
            clk_prev <= clk_filt;
            if (clk_filt && !clk_prev) begin
                since_rise <= 32'h00000000;
                clock_alive <= 1'b1;
            end else begin
                since_rise <= bump(since_rise);
                if (reached(since_rise, CLOCK_LOSS_CYC)) begin
                    clock_alive <= 1'b0;
                end
            end
        end
    end

    // =================================================================
    // Enable decision

    wire enabled;

    // Output path ignores the LED delay entirely
    assign enabled = in_enable && !lockout && !setting_aid
        && reached(dwell, ENABLE_TIME_CYC);

    // Safety output: fault beats everything, otherwise gated clock
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            safety_out <= 1'b0;
        end else if (cross_fault) begin
            safety_out <= 1'b1;
        end else if (enabled && clock_alive) begin
            safety_out <= clk_pass;
        end else begin
            safety_out <= 1'b0;
        end
    end

    // =================================================================
    // Yellow indicator

    reg [31:0] flash_cnt;
    reg flash;
    reg [31:0] fault_cnt;
    reg fault_flash;

    // Slow blink for setting aid, fast blink for a fault
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flash_cnt <= 32'h00000000;
            flash <= 1'b0;
            fault_cnt <= 32'h00000000;
            fault_flash <= 1'b0;
        end else begin
            if (reached(flash_cnt, FLASH_HALF_CYC - 32'h00000001)) begin
                flash_cnt <= 32'h00000000;
                flash <= !flash;
            end else begin
                flash_cnt <= bump(flash_cnt);
            end
            if (reached(fault_cnt, FAULT_HALF_CYC - 32'h00000001)) begin
                fault_cnt <= 32'h00000000;
                fault_flash <= !fault_flash;
            end else begin
                fault_cnt <= bump(fault_cnt);
            end
        end
    end

    reg next_led;

    // Lit state carries into the close zone and dies there after the dwell
    always @* begin
        next_led = 1'b0;
        if (cross_fault) begin
            next_led = fault_flash;
        end else if (setting_aid) begin
            next_led = in_enable ? 1'b0 : flash;
        end else if (in_enable && !lockout) begin
            if (entering_enable) begin
                next_led = !led_delay_armed;
            end else if (led_delay_mode) begin
                next_led = reached(dwell, LED_DELAY_CYC);
            end else begin
                next_led = 1'b1;
            end
        end else if (in_close) begin
            next_led = led_yellow && !reached(dwell, CLOSE_DWELL_CYC);
        end else begin
            next_led = 1'b0;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            led_yellow <= 1'b0;
        end else begin
            led_yellow <= next_led;
        end
    end

endmodule

/* File: rtl/fps_output_control_defs.vh */
// Constants of the proximity output control: zone codes, times and cycle counts
`ifndef FPS_OUTPUT_CONTROL_DEFS_VH
`define FPS_OUTPUT_CONTROL_DEFS_VH

// =====================================================================
// Clock rate
`define FPS_CLK_HZ 32'd50000000
`define FPS_CLK_KHZ 32'd50000
`define FPS_CLK_MHZ 32'd50

// =====================================================================
// Zone codes (reset value of the zone register is FPS_ZONE_OUTSIDE)
`define FPS_ZONE_UNDAMPED 2'h0
`define FPS_ZONE_CLOSE 2'h1
`define FPS_ZONE_ENABLE 2'h2
`define FPS_ZONE_OUTSIDE 2'h3

// =====================================================================
// Times in their own units
`define FPS_CLOSE_DWELL_S 32'd2
`define FPS_UNDAMP_RELEASE_S 32'd2
`define FPS_LED_DELAY_S 32'd3
`define FPS_AID_DELAY_S 32'd5
`define FPS_ENABLE_TIME_MS 32'd100
`define FPS_TEST_PULSE_US 32'd1000
`define FPS_OFFSET_US 32'd100
`define FPS_CLOCK_LOSS_US 32'd1800
`define FPS_FLASH_HZ 32'd2
`define FPS_FAULT_FLASH_HZ 32'd5

// =====================================================================
// Cycle counts derived from the times
`define FPS_CLOSE_DWELL_CYC (`FPS_CLOSE_DWELL_S * `FPS_CLK_HZ)
`define FPS_UNDAMP_RELEASE_CYC (`FPS_UNDAMP_RELEASE_S * `FPS_CLK_HZ)
`define FPS_LED_DELAY_CYC (`FPS_LED_DELAY_S * `FPS_CLK_HZ)
`define FPS_AID_DELAY_CYC (`FPS_AID_DELAY_S * `FPS_CLK_HZ)
`define FPS_ENABLE_TIME_CYC (`FPS_ENABLE_TIME_MS * `FPS_CLK_KHZ)
`define FPS_TEST_PULSE_CYC (`FPS_TEST_PULSE_US * `FPS_CLK_MHZ)
`define FPS_OFFSET_CYC (`FPS_OFFSET_US * `FPS_CLK_MHZ)
`define FPS_CLOCK_LOSS_CYC (`FPS_CLOCK_LOSS_US * `FPS_CLK_MHZ)
`define FPS_FLASH_HALF_CYC (`FPS_CLK_HZ / (32'd2 * `FPS_FLASH_HZ))
`define FPS_FAULT_HALF_CYC (`FPS_CLK_HZ / (32'd2 * `FPS_FAULT_FLASH_HZ))

`endif

/* File: verification/fps_output_control_checker.sv */
// Assertion checker for the proximity output control
`timescale 1ns/1ps
module fps_output_control_checker #(
    parameter [31:0] CLOSE_DWELL_CYC = 32'hC8,
    parameter [31:0] UNDAMP_RELEASE_CYC = 32'hC8,
    parameter [31:0] AID_DELAY_CYC = 32'h1F4,
    parameter [31:0] TEST_PULSE_CYC = 32'hA,
    parameter [31:0] OFFSET_CYC = 32'h4
)(
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Zones and pins
    input wire zone_close,
    input wire zone_enable,
    input wire zone_undamped,
    input wire test_clock_input,
    input wire cross_fault_pin,
    // Outputs
    input wire safety_out,
    input wire led_yellow
);
    reg [31:0] close_cnt;
    reg [31:0] und_cnt;
    reg [31:0] low_cnt;
    reg [2:0] cross_cnt;
    reg lock;
    reg aid;
    wire clean = (cross_cnt == 3'h0);

    // =====================================================================
    // Shadow state, set 3 cycles late so it never runs ahead of the design
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            close_cnt <= 32'h0;
            und_cnt <= 32'h0;
            low_cnt <= 32'h0;
            cross_cnt <= 3'h0;
            lock <= 1'b0;
            aid <= 1'b0;
        end else begin
            close_cnt <= zone_close ? close_cnt + 32'h1 : 32'h0;
            und_cnt <= (zone_undamped && !zone_close && !zone_enable) ? und_cnt + 32'h1 : 32'h0;
            low_cnt <= test_clock_input ? 32'h0 : low_cnt + 32'h1;
            if ((cross_fault_pin || !clean) && cross_cnt != 3'h7) begin
                cross_cnt <= cross_cnt + 3'h1;
            end
            if (close_cnt == CLOSE_DWELL_CYC + 32'h3) begin
                lock <= 1'b1;
            end else if (und_cnt == UNDAMP_RELEASE_CYC + 32'h3) begin
                lock <= 1'b0;
            end
            if (close_cnt == AID_DELAY_CYC + 32'h3) begin
                aid <= 1'b1;
            end else if (und_cnt == UNDAMP_RELEASE_CYC + 32'h3) begin
                aid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Properties
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_away;
        (!zone_enable || zone_close) [*4];
    endsequence
    sequence s_aid_close;
        (aid && zone_close) [*4];
    endsequence

    a_out_needs_zone: assert property (s_away ##0 clean |-> !safety_out)
        else $error("output high outside the enable zone");
    a_lock_blocks: assert property (lock && clean |-> !safety_out)
        else $error("output high during lockout");
    a_cross_raise: assert property ($rose(cross_fault_pin) |-> ##[1:6] safety_out)
        else $error("cross fault not signalled in time");
    a_cross_holds: assert property (cross_cnt == 3'h7 |-> safety_out)
        else $error("cross fault level not held");
    a_clock_loss: assert property (low_cnt == TEST_PULSE_CYC + OFFSET_CYC + 32'h8 && clean |-> !safety_out)
        else $error("output still high after test clock stopped");
    a_undamp_led_off: assert property ((zone_undamped && !zone_enable && !zone_close) [*4] ##0 (!aid && clean)
        |-> !led_yellow)
        else $error("indicator lit while undamped");
    a_aid_flash: assert property (s_aid_close |-> ##[1:40] ($changed(led_yellow) || !zone_close))
        else $error("indicator not flashing in setting aid");
    a_aid_dark: assert property ((aid && zone_enable && !zone_close) [*4] |-> !led_yellow)
        else $error("indicator lit in enable zone during setting aid");
endmodule

bind fps_output_control fps_output_control_checker #(.CLOSE_DWELL_CYC(CLOSE_DWELL_CYC),
    .UNDAMP_RELEASE_CYC(UNDAMP_RELEASE_CYC), .AID_DELAY_CYC(AID_DELAY_CYC), .TEST_PULSE_CYC(TEST_PULSE_CYC),
    .OFFSET_CYC(OFFSET_CYC)) u_checker (.clk(clk), .reset_n(reset_n), .zone_close(zone_close),
    .zone_enable(zone_enable), .zone_undamped(zone_undamped), .test_clock_input(test_clock_input),
    .cross_fault_pin(cross_fault_pin), .safety_out(safety_out), .led_yellow(led_yellow));

/* File: verification/fps_monitor_unit.sv */
// Model of the monitoring unit that drives the test clock pin
`timescale 1ns/1ps
module fps_monitor_unit (
    // Clock and control
    input wire clk,
    input wire run,
    input wire [7:0] high_cyc,
    input wire [7:0] low_cyc,
    // Test clock pin
    output logic test_clock_input
);
    logic [7:0] cnt = 8'h0;
    initial test_clock_input = 1'b0;

    // =====================================================================
    // Clock generator; a stopped unit leaves the pin at the safe low level
    always @(posedge clk) begin
        if (!run) begin
            test_clock_input <= 1'b0;
            cnt <= 8'h0;
        end else if (cnt + 8'h1 >= (test_clock_input ? high_cyc : low_cyc)) begin
            test_clock_input <= !test_clock_input;
            cnt <= 8'h0;
        end else begin
            cnt <= cnt + 8'h1;
        end
    end
endmodule

/* File: verification/testbench.sv */
// Self-checking testbench of the proximity output control
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic zone_close = 1'b0;
    logic zone_enable = 1'b0;
    logic zone_undamped = 1'b0;
    logic cross_fault_pin = 1'b0;
    logic run = 1'b0;
    logic [7:0] high_cyc = 8'h14;
    logic [7:0] low_cyc = 8'h14;
    wire test_clock_input;
    wire safety_out;
    wire led_yellow;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    // =====================================================================
    // Clock, partner and design; short counts keep the run brief
    initial forever #10 clk = ~clk;
    fps_monitor_unit partner (.clk(clk), .run(run), .high_cyc(high_cyc), .low_cyc(low_cyc),
        .test_clock_input(test_clock_input));
    // Shortened counts, named once so every override is traceable
    localparam logic [31:0] T_CLOSE = 32'hC8;
    localparam logic [31:0] T_UNDAMP = 32'hC8;
    localparam logic [31:0] T_LED = 32'h12C;
    localparam logic [31:0] T_AID = 32'h1F4;
    localparam logic [31:0] T_ENABLE = 32'h14;
    localparam logic [31:0] T_PULSE = 32'hA;
    localparam logic [31:0] T_OFFSET = 32'h4;
    localparam logic [31:0] T_LOSS = 32'h3C;
    localparam logic [31:0] T_FLASH = 32'h10;
    localparam logic [31:0] T_FAULT = 32'h8;
    fps_output_control #(.CLOSE_DWELL_CYC(T_CLOSE), .UNDAMP_RELEASE_CYC(T_UNDAMP), .LED_DELAY_CYC(T_LED),
        .AID_DELAY_CYC(T_AID), .ENABLE_TIME_CYC(T_ENABLE), .TEST_PULSE_CYC(T_PULSE), .OFFSET_CYC(T_OFFSET),
        .CLOCK_LOSS_CYC(T_LOSS), .FLASH_HALF_CYC(T_FLASH), .FAULT_HALF_CYC(T_FAULT)) dut (.clk(clk),
        .reset_n(reset_n), .zone_close(zone_close), .zone_enable(zone_enable), .zone_undamped(zone_undamped),
        .test_clock_input(test_clock_input), .cross_fault_pin(cross_fault_pin), .safety_out(safety_out),
        .led_yellow(led_yellow));

    // =====================================================================
    // Helpers
    task tally_and_finish;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task check_num(input int got, input int exp);
        comparisons++;
        if (got != exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task zone(input logic c, input logic e, input logic u);
        @(negedge clk);
        zone_close = c;
        zone_enable = e;
        zone_undamped = u;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Counts cycles in which the chosen output is high
    task count_high(input int n, input logic sel, output int k);
        k = 0;
        repeat (n) begin
            @(negedge clk);
            k += ((sel ? led_yellow : safety_out) === 1'b1);
        end
    endtask

    // =====================================================================
    // Scenarios
    task s_power_on;
        int k;
        zone(0, 0, 1);
        cyc(20);
        zone(0, 1, 0);
        count_high(150, 0, k);
        check_bit(k != 0, 1'b1);
        check_bit(led_yellow, 1'b0);
        cyc(160);
        check_bit(led_yellow, 1'b1);
        zone(0, 0, 1);
        cyc(3);
        check_bit(safety_out, 1'b0);
        check_bit(led_yellow, 1'b0);
        cyc(47);
        zone(0, 1, 0);
        cyc(3);
        check_bit(led_yellow, 1'b1);
    endtask
    // One low pulse of 8 cycles must not break the passed high level
    task s_test_pulse;
        int k;
        cyc(60);
        low_cyc = 8'h8;
        while (test_clock_input !== 1'b0) @(negedge clk);
        cyc(2);
        count_high(30, 0, k);
        low_cyc = 8'h14;
        check_num(k, 30);
        zone(0, 0, 0);
        cyc(3);
        count_high(60, 0, k);
        check_num(k, 0);
    endtask
    task s_lock;
        int k;
        zone(0, 1, 0);
        cyc(5);
        zone(1, 0, 0);
        cyc(3);
        check_bit(safety_out, 1'b0);
        cyc(100);
        check_bit(led_yellow, 1'b1);
        cyc(110);
        check_bit(led_yellow, 1'b0);
        cyc(50);
        zone(0, 1, 0);
        count_high(100, 0, k);
        check_num(k, 0);
        zone(0, 0, 1);
        cyc(250);
        zone(0, 1, 0);
        count_high(150, 0, k);
        check_bit(k != 0, 1'b1);
    endtask
    task s_aid;
        int k;
        zone(1, 0, 0);
        cyc(520);
        count_high(64, 1, k);
        check_bit(k >= 16 && k <= 48, 1'b1);
        zone(0, 1, 0);
        cyc(3);
        count_high(50, 1, k);
        check_num(k, 0);
        count_high(50, 0, k);
        check_num(k, 0);
        zone(0, 0, 0);
        cyc(3);
        count_high(64, 1, k);
        check_bit(k >= 16 && k <= 48, 1'b1);
        zone(0, 0, 1);
        cyc(250);
        check_bit(led_yellow, 1'b0);
        zone(0, 1, 0);
        count_high(150, 0, k);
        check_bit(k != 0, 1'b1);
    endtask
    task s_clock_off;
        int k;
        run = 1'b0;
        cyc(25);
        count_high(40, 0, k);
        check_num(k, 0);
    endtask
    task s_cross;
        int k;
        zone(0, 0, 1);
        cross_fault_pin = 1'b1;
        cyc(3);
        cross_fault_pin = 1'b0;
        cyc(6);
        count_high(100, 0, k);
        check_num(k, 100);
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        run = 1'b1;
        s_power_on();
        s_test_pulse();
        s_lock();
        s_aid();
        s_clock_off();
        s_cross();
        tally_and_finish();
    end
endmodule
